// file: touch_probe_position_latch.sv
// Dual-channel touch probe position latch with object access port
`timescale 1ns/1ns
//
// Behaviour
// - Status bits 0 and 8 mirror channel enables
// - Channel one rise/fall stored flags, bits 1,2
// - Channel two rise/fall stored flags, bits 9,10
// - Continuous mode two-bit wrapping count per channel
// - Hold channel one rising-edge position, signed 32
// - Hold channel one falling-edge position, signed 32
// - Hold channel two rising-edge position, signed 32
// - Hold channel two falling-edge position, signed 32
// - Probe input filter, 0-1000 x 10 ns, immediate
// - Pin choice 0-2 per channel, applied at restart
// - Polarity 0 active low, 1 active high, restart
// - Control bits 0 and 8 enable channels
// - Mode bit: single first event or continuous
// - Source bit: probe input or encoder zero
// - Separate rising and falling edge enables
module touch_probe_position_latch
    import touch_probe_pkg::*;
#(
    parameter int POS_W    = 32,
    parameter int NUM_PINS = 3
)(
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_b_i,
    // Probe pins and encoder zero pulse, asynchronous
    input  wire logic [NUM_PINS-1:0]     probe_pin_i,
    input  wire logic                    encoder_zero_i,
    // Feedback position, same clock
    input  wire logic signed [POS_W-1:0] feedback_pos_i,
    // Drive parameters
    input  wire logic [1:0]              probe1_pin_select_i,
    input  wire logic [1:0]              probe2_pin_select_i,
    input  wire logic                    probe1_polarity_i,
    input  wire logic                    probe2_polarity_i,
    input  wire logic [FILT_TIME_W-1:0]  probe_filter_time_i,
    // Object access port
    input  wire logic [15:0]             obj_index_i,
    input  wire logic                    obj_rd_i,
    input  wire logic                    obj_wr_i,
    input  wire logic [31:0]             obj_wdata_i,
    output logic [31:0]                  obj_rdata_o,
    output logic                         obj_ack_o,
    output logic                         obj_err_o
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (POS_W != 32)
    begin : g_bad_pos
        $error("POS_W must be 32 to fit the position objects");
    end
    if (NUM_PINS < 3)
    begin : g_bad_pins
        $error("NUM_PINS must be at least 3 for pin choices 0 to 2");
    end

    logic [NUM_PINS-1:0]     pin_meta_q;
    logic [NUM_PINS-1:0]     pin_sync_q;
    logic                    zero_meta_q;
    logic                    zero_sync_q;
    logic [1:0]              settle_q;
    logic                    cfg_loaded_q;
    logic [1:0]              pin_sel_q [2];
    logic                    polarity_q [2];
    logic [15:0]             control_q;
    logic [FILT_TIME_W-1:0]  filt_time;
    logic [FILT_CYC_W-1:0]   filt_cycles;
    logic                    raw_level [2];
    logic                    filt_level [2];
    logic                    trig_level [2];
    logic signed [POS_W-1:0] rise_pos [2];
    logic signed [POS_W-1:0] fall_pos [2];
    logic                    rise_stored [2];
    logic                    fall_stored [2];
    logic [CNT_W-1:0]        count [2];
    logic [15:0]             status_word;
    logic                    idx_known;
    logic                    wr_ok;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Flops reset low, which looks active to a low-active probe, so
    // settle_q keeps filter inputs idle until the pin reaches stage two
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            settle_q    <= '0;
            pin_meta_q  <= '0;
            pin_sync_q  <= '0;
            zero_meta_q <= 1'b0;
            zero_sync_q <= 1'b0;
        end
        else
        begin
            pin_meta_q  <= probe_pin_i;
            pin_sync_q  <= pin_meta_q;
            zero_meta_q <= encoder_zero_i;
            zero_sync_q <= zero_meta_q;
            settle_q    <= {settle_q[0], 1'b1};
        end
    end

    // ------------------------------------------------------------
    // Restart-time settings
    // ------------------------------------------------------------
    // Taken once, on the first edge after reset release, so a later
    // change of the inputs only acts after the next restart
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cfg_loaded_q  <= 1'b0;
            pin_sel_q[0]  <= P1_PIN_DEFAULT;
            pin_sel_q[1]  <= P2_PIN_DEFAULT;
            polarity_q[0] <= POL_DEFAULT;
            polarity_q[1] <= POL_DEFAULT;
        end
        else if (!cfg_loaded_q)
        begin
            cfg_loaded_q  <= 1'b1;
            pin_sel_q[0]  <= probe1_pin_select_i;
            pin_sel_q[1]  <= probe2_pin_select_i;
            polarity_q[0] <= probe1_polarity_i;
            polarity_q[1] <= probe2_polarity_i;
        end
    end

    // ------------------------------------------------------------
    // Filter time in clock cycles, rounded up
    // ------------------------------------------------------------
    // Applies at once; values past the top of range are clamped
    assign filt_time = (probe_filter_time_i > FILT_TIME_MAX) ?
                       FILT_TIME_MAX : probe_filter_time_i;
    assign filt_cycles = FILT_CYC_W'(((FILT_CYC_W'(filt_time) * FILT_CYC_W'(FILT_STEP_NS))
                         + FILT_CYC_W'(CLK_PERIOD_NS - 1)) / FILT_CYC_W'(CLK_PERIOD_NS));

    // ------------------------------------------------------------
    // Per-channel input path and latch
    // ------------------------------------------------------------
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_ch
        // Out-of-range pin choice falls back to pin 0
        always_comb
        begin
            if (pin_sel_q[ch] > PIN_SEL_MAX)
                raw_level[ch] = pin_sync_q[0];
            else
                raw_level[ch] = pin_sync_q[pin_sel_q[ch]];
        end

        // Active level: inverted pin for setting 0, pin itself for 1
        probe_input_filter #(
            .LIM_W (FILT_CYC_W)
        ) u_filter (
            .clk_sys_i (clk_sys_i),
            .rst_b_i   (rst_b_i),
            .level_i   (settle_q[1] &&
                        (polarity_q[ch] ? raw_level[ch] : !raw_level[ch])),
            .limit_i   (filt_cycles),
            .level_o   (filt_level[ch])
        );

        // Zero pulse bypasses the probe filter
        assign trig_level[ch] = control_q[ch*CH2_OFS + CTL_SRC] ?
                                zero_sync_q : filt_level[ch];

        probe_latch_channel #(
            .POS_W (POS_W)
        ) u_latch (
            .clk_sys_i     (clk_sys_i),
            .rst_b_i       (rst_b_i),
            .enable_i      (control_q[ch*CH2_OFS + CTL_EN]),
            .continuous_i  (control_q[ch*CH2_OFS + CTL_MODE]),
            .rise_en_i     (control_q[ch*CH2_OFS + CTL_RISE]),
            .fall_en_i     (control_q[ch*CH2_OFS + CTL_FALL]),
            .trig_i        (trig_level[ch]),
            .pos_i         (feedback_pos_i),
            .rise_pos_o    (rise_pos[ch]),
            .fall_pos_o    (fall_pos[ch]),
            .rise_stored_o (rise_stored[ch]),
            .fall_stored_o (fall_stored[ch]),
            .count_o       (count[ch])
        );
    end

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    // Reserved bits read as zero
    always_comb
    begin
        status_word = '0;
        for (int c = 0; c < 2; c++)
        begin
            status_word[c*CH2_OFS + ST_EN]   = control_q[c*CH2_OFS + CTL_EN];
            status_word[c*CH2_OFS + ST_RISE] = rise_stored[c];
            status_word[c*CH2_OFS + ST_FALL] = fall_stored[c];
            status_word[c*CH2_OFS + ST_CNT +: CNT_W] = count[c];
        end
    end

    // ------------------------------------------------------------
    // Object access
    // ------------------------------------------------------------
    assign idx_known = (obj_index_i >= IDX_CONTROL) && (obj_index_i <= IDX_P2_FALL);
    assign wr_ok     = obj_wr_i && (obj_index_i == IDX_CONTROL);

    // Control word: the only writable object
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            control_q <= CONTROL_RESET;
        else if (wr_ok)
            control_q <= obj_wdata_i[15:0];
    end

    // Answer one cycle after any read or write; a write wins over a
    // read offered in the same cycle
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            obj_rdata_o <= '0;
            obj_ack_o   <= 1'b0;
            obj_err_o   <= 1'b0;
        end
        else
        begin
            obj_ack_o <= obj_rd_i || obj_wr_i;
            obj_err_o <= (obj_rd_i || obj_wr_i) &&
                         (!idx_known || (obj_wr_i && !wr_ok));
            if (obj_rd_i && !obj_wr_i)
            begin
                unique case (obj_index_i)
                    IDX_CONTROL: obj_rdata_o <= {16'h0000, control_q};
                    IDX_STATUS:  obj_rdata_o <= {16'h0000, status_word};
                    IDX_P1_RISE: obj_rdata_o <= rise_pos[0];
                    IDX_P1_FALL: obj_rdata_o <= fall_pos[0];
                    IDX_P2_RISE: obj_rdata_o <= rise_pos[1];
                    IDX_P2_FALL: obj_rdata_o <= fall_pos[1];
                    default:     obj_rdata_o <= '0;
                endcase
            end
        end
    end

endmodule // touch_probe_position_latch

// file: touch_probe_pkg.sv
// Constants shared by the touch probe position latch
package touch_probe_pkg;

    // ------------------------------------------------------------
    // Object indices
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_CONTROL   = 16'h60B8;
    localparam logic [15:0] IDX_STATUS    = 16'h60B9;
    localparam logic [15:0] IDX_P1_RISE   = 16'h60BA;
    localparam logic [15:0] IDX_P1_FALL   = 16'h60BB;
    localparam logic [15:0] IDX_P2_RISE   = 16'h60BC;
    localparam logic [15:0] IDX_P2_FALL   = 16'h60BD;

    // ------------------------------------------------------------
    // Control word fields (channel two is offset by CH2_OFS)
    // ------------------------------------------------------------
    localparam int CTL_EN      = 0;
    localparam int CTL_MODE    = 1;
    localparam int CTL_SRC     = 2;
    localparam int CTL_RISE    = 4;
    localparam int CTL_FALL    = 5;
    localparam int CH2_OFS     = 8;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Status word fields
    // ------------------------------------------------------------
    localparam int ST_EN       = 0;
    localparam int ST_RISE     = 1;
    localparam int ST_FALL     = 2;
    localparam int ST_CNT      = 6;
    localparam int CNT_W       = 2;

    // ------------------------------------------------------------
    // Restart-time settings and filter timing
    // ------------------------------------------------------------
    localparam logic [1:0] P1_PIN_DEFAULT = 2'h0;
    localparam logic [1:0] P2_PIN_DEFAULT = 2'h1;
    localparam logic [1:0] PIN_SEL_MAX    = 2'h2;
    localparam logic       POL_DEFAULT    = 1'b0;
    localparam int         FILT_TIME_W    = 10;
    localparam logic [9:0] FILT_TIME_MAX  = 10'h3E8;
    localparam int         FILT_STEP_NS   = 10;
    localparam int         CLK_PERIOD_NS  = 40;
    localparam int         FILT_CYC_W     = 14;

endpackage : touch_probe_pkg

// file: probe_input_filter.sv
// Stability filter for one conditioned probe input level
`timescale 1ns/1ns
module probe_input_filter
    import touch_probe_pkg::*;
#(
    parameter int LIM_W = FILT_CYC_W
)(
    input  wire logic             clk_sys_i,
    input  wire logic             rst_b_i,
    input  wire logic             level_i,
    input  wire logic [LIM_W-1:0] limit_i,
    output logic                  level_o
);

    logic             stable_q;
    logic [LIM_W-1:0] run_q;

    // ------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------
    // A new level is taken only once it has differed from the held
    // level for limit_i cycles; a limit of zero or one passes at once
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            stable_q <= 1'b0;
            run_q    <= '0;
        end
        else if (level_i == stable_q)
        begin
            run_q <= '0;
        end
        else if ((run_q + LIM_W'(1)) >= limit_i)
        begin
            stable_q <= level_i;
            run_q    <= '0;
        end
        else
        begin
            run_q <= run_q + LIM_W'(1);
        end
    end

    assign level_o = stable_q;

endmodule // probe_input_filter

// file: probe_latch_channel.sv
// One probe channel: edge detection, position capture and flags
`timescale 1ns/1ns
module probe_latch_channel
    import touch_probe_pkg::*;
#(
    parameter int POS_W = 32
)(
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_b_i,
    input  wire logic                    enable_i,
    input  wire logic                    continuous_i,
    input  wire logic                    rise_en_i,
    input  wire logic                    fall_en_i,
    input  wire logic                    trig_i,
    input  wire logic signed [POS_W-1:0] pos_i,
    output logic signed [POS_W-1:0]      rise_pos_o,
    output logic signed [POS_W-1:0]      fall_pos_o,
    output logic                         rise_stored_o,
    output logic                         fall_stored_o,
    output logic [CNT_W-1:0]             count_o
);

    logic prev_q;
    logic rise_hit;
    logic fall_hit;

    // ------------------------------------------------------------
    // Edge qualification
    // ------------------------------------------------------------
    // Previous level tracks even while disabled, so enabling with
    // the input already active does not fake an edge
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            prev_q <= 1'b0;
        else
            prev_q <= trig_i;
    end

    // Single mode latches each edge once; continuous every time
    assign rise_hit = enable_i && rise_en_i && trig_i && !prev_q
                      && (continuous_i || !rise_stored_o);
    assign fall_hit = enable_i && fall_en_i && !trig_i && prev_q
                      && (continuous_i || !fall_stored_o);

    // ------------------------------------------------------------
    // Captured positions
    // ------------------------------------------------------------
    // Position is taken in the same cycle as the edge
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rise_pos_o <= '0;
            fall_pos_o <= '0;
        end
        else
        begin
            if (rise_hit)
                rise_pos_o <= pos_i;
            if (fall_hit)
                fall_pos_o <= pos_i;
        end
    end

    // ------------------------------------------------------------
    // Stored flags and execution count
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rise_stored_o <= 1'b0;
            fall_stored_o <= 1'b0;
            count_o       <= '0;
        end
        else if (!enable_i)
        begin
            rise_stored_o <= 1'b0;
            fall_stored_o <= 1'b0;
            count_o       <= '0;
        end
        else
        begin
            if (rise_hit)
                rise_stored_o <= 1'b1;
            if (fall_hit)
                fall_stored_o <= 1'b1;
            if (continuous_i && (rise_hit || fall_hit))
                count_o <= count_o + CNT_W'(1);
        end
    end

endmodule // probe_latch_channel

// file: probe_sensor_model.sv
// Behavioural probe sensors and encoder zero pulse for the latch bench
`timescale 1ns/1ns
module probe_sensor_model
#(
    parameter int NUM_PINS = 3
)(
    input  wire logic [NUM_PINS-1:0] active_i,
    input  wire logic [NUM_PINS-1:0] high_i,
    input  wire logic                zero_i,
    output logic [NUM_PINS-1:0]      pin_o,
    output logic                     zero_o
);
    // Low-active sensors idle high, so a released contact never reads as a hit
    assign pin_o  = ~(active_i ^ high_i);
    // Zero pulse is a plain active-high level with no conditioning
    assign zero_o = zero_i;
endmodule // probe_sensor_model

// file: touch_probe_position_latch_checker.sv
// Concurrent checks on the object port of the touch probe latch
`timescale 1ns/1ns
module touch_probe_position_latch_checker
    import touch_probe_pkg::*;
(
    input wire logic                    clk_sys_i,
    input wire logic                    rst_b_i,
    input wire logic [15:0]             obj_index_i,
    input wire logic                    obj_rd_i,
    input wire logic                    obj_wr_i,
    input wire logic [31:0]             obj_wdata_i,
    input wire logic [31:0]             obj_rdata_o,
    input wire logic                    obj_ack_o,
    input wire logic                    obj_err_o
);
    logic [15:0] ctl_q;
    logic        req;
    logic        rd_only;
    logic        mapped;
    logic        is_st;
    assign req     = obj_rd_i | obj_wr_i;
    assign rd_only = obj_rd_i & ~obj_wr_i;
    assign mapped  = (obj_index_i >= IDX_CONTROL) && (obj_index_i <= IDX_P2_FALL);
    assign is_st   = rd_only && (obj_index_i == IDX_STATUS);
    // Shadow of the control word, so readback is judged without the design
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ctl_q <= CONTROL_RESET;
        end
        else if (obj_wr_i && (obj_index_i == IDX_CONTROL))
        begin
            ctl_q <= obj_wdata_i[15:0];
        end
    end
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);
    // ------------------------------------------------------------
    // Object port
    // ------------------------------------------------------------
    a_ack_after_req: assert property (req |=> obj_ack_o)
        else $error("request without answer");
    a_ack_no_spurious: assert property (!req |=> !obj_ack_o)
        else $error("answer without request");
    a_err_unmapped: assert property ((req && !mapped) |=> obj_err_o
        && (!$past(rd_only) || obj_rdata_o == 32'h0))
        else $error("unmapped index not refused");
    a_err_ro_write: assert property (obj_wr_i && mapped && obj_index_i != IDX_CONTROL
        |=> obj_err_o)
        else $error("write to read-only object accepted");
    a_ctl_write_ok: assert property (obj_wr_i && obj_index_i == IDX_CONTROL
        |=> !obj_err_o)
        else $error("control write refused");
    a_ctl_read_back: assert property ((rd_only && obj_index_i == IDX_CONTROL)
        |=> obj_rdata_o == {16'h0000, $past(ctl_q)})
        else $error("control readback differs");
    a_status_enable_bits: assert property (is_st
        |=> obj_rdata_o[ST_EN] == $past(ctl_q[CTL_EN])
        && obj_rdata_o[ST_EN+CH2_OFS] == $past(ctl_q[CTL_EN+CH2_OFS]))
        else $error("status enable bits differ from control");
    a_disabled_flags_clear: assert property (is_st && !ctl_q[CTL_EN]
        && !$past(ctl_q[CTL_EN]) |=> obj_rdata_o[7:1] == 7'h00)
        else $error("disabled channel shows flags");
    a_rdata_hold: assert property (!rd_only |=> $stable(obj_rdata_o))
        else $error("read data moved without read");
    c_rise_seen: cover property (is_st ##1 obj_rdata_o[ST_RISE]);
    c_count_seen: cover property (is_st ##1 obj_rdata_o[15:14] != 2'h0);
    c_err_seen: cover property (obj_ack_o && obj_err_o);
endmodule // touch_probe_position_latch_checker

// file: touch_probe_position_latch_tb.sv
// Self-checking testbench for the touch probe position latch
`timescale 1ns/1ns
module touch_probe_position_latch_tb;
    import touch_probe_pkg::*;
    logic               clk_sys_i;
    logic               rst_b_i;
    logic [2:0]         probe_pin_i;
    logic               encoder_zero_i;
    logic signed [31:0] feedback_pos_i;
    logic [1:0]         probe1_pin_select_i;
    logic [1:0]         probe2_pin_select_i;
    logic               probe1_polarity_i;
    logic               probe2_polarity_i;
    logic [9:0]         probe_filter_time_i;
    logic [15:0]        obj_index_i;
    logic               obj_rd_i;
    logic               obj_wr_i;
    logic [31:0]        obj_wdata_i;
    logic [31:0]        obj_rdata_o;
    logic               obj_ack_o;
    logic               obj_err_o;
    logic [2:0]         pin_active;
    logic [2:0]         pin_high;
    logic               zero_req;
    logic [33:0]        exp_q[$];
    logic [33:0]        e_cur;
    logic [31:0]        pos[0:7];
    int                 bad_count;
    int                 n_tests;

    touch_probe_position_latch i_touch_probe_position_latch (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .probe_pin_i(probe_pin_i),
        .encoder_zero_i(encoder_zero_i), .feedback_pos_i(feedback_pos_i),
        .probe1_pin_select_i(probe1_pin_select_i), .probe2_pin_select_i(probe2_pin_select_i),
        .probe1_polarity_i(probe1_polarity_i), .probe2_polarity_i(probe2_polarity_i),
        .probe_filter_time_i(probe_filter_time_i), .obj_index_i(obj_index_i),
        .obj_rd_i(obj_rd_i), .obj_wr_i(obj_wr_i), .obj_wdata_i(obj_wdata_i),
        .obj_rdata_o(obj_rdata_o), .obj_ack_o(obj_ack_o), .obj_err_o(obj_err_o));
    probe_sensor_model i_probe_sensor_model (
        .active_i(pin_active), .high_i(pin_high), .zero_i(zero_req),
        .pin_o(probe_pin_i), .zero_o(encoder_zero_i));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial
    begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // One object request; the answer is noted for the watcher below
    task automatic xfer(input logic [15:0] idx, input logic wr, input logic [31:0] d,
                        input logic err, input logic [31:0] data);
        @(posedge clk_sys_i);
        obj_index_i <= idx;
        obj_rd_i    <= ~wr;
        obj_wr_i    <= wr;
        obj_wdata_i <= d;
        exp_q.push_back({wr, err, data});
        @(posedge clk_sys_i);
        obj_rd_i    <= 1'b0;
        obj_wr_i    <= 1'b0;
    endtask
    // Move one trigger line (3 = zero pulse) with a fresh random position
    task automatic drive(input int pin, input logic act, input int k, input int hold);
        @(posedge clk_sys_i);
        pos[k] = $urandom;
        feedback_pos_i <= pos[k];
        if (pin == 3)
            zero_req <= act;
        else
            pin_active[pin] <= act;
        repeat (hold) @(posedge clk_sys_i);
    endtask
    // Answers are sampled mid-cycle, well clear of the launching edge
    always @(negedge clk_sys_i)
    begin
        if (rst_b_i === 1'b1 && obj_ack_o === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("unexpected answer", 32'h1, 32'h0);
            else
            begin
                e_cur = exp_q.pop_front();
                chk("obj_err_o", {31'h0, obj_err_o}, {31'h0, e_cur[32]});
                if (!e_cur[33])
                    chk("obj_rdata_o", obj_rdata_o, e_cur[31:0]);
            end
        end
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        bad_count++;
        $display("Error watchdog expected finish seen timeout");
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        {rst_b_i, obj_rd_i, obj_wr_i, zero_req} = 4'h0;
        {probe1_polarity_i, probe2_polarity_i, pin_active, pin_high} = 8'h00;
        {obj_index_i, obj_wdata_i, feedback_pos_i} = 80'h0;
        probe1_pin_select_i = 2'h0;
        probe2_pin_select_i = 2'h1;
        probe_filter_time_i = 10'h000;
        bad_count = 0;
        n_tests = 0;
        void'($urandom(32'h4CA3));
        repeat (6) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        xfer(IDX_STATUS, 1'b0, 32'h0, 1'b0, 32'h0);
        xfer(16'h1234, 1'b0, 32'h0, 1'b1, 32'h0);
        xfer(IDX_P1_RISE, 1'b1, 32'h5A5A, 1'b1, 32'h0);
        xfer(IDX_CONTROL, 1'b1, 32'h0031, 1'b0, 32'h0);
        xfer(IDX_CONTROL, 1'b0, 32'h0, 1'b0, 32'h0031);
        xfer(IDX_STATUS, 1'b0, 32'h0, 1'b0, 32'h0001);
        $display("test access and enable done");
        drive(0, 1'b1, 0, 8);
        xfer(IDX_STATUS, 1'b0, 32'h0, 1'b0, 32'h0003);
        drive(0, 1'b0, 1, 8);
        xfer(IDX_STATUS, 1'b0, 32'h0, 1'b0, 32'h0007);
        drive(0, 1'b1, 7, 8);
        xfer(IDX_P1_RISE, 1'b0, 32'h0, 1'b0, pos[0]);
        xfer(IDX_P1_FALL, 1'b0, 32'h0, 1'b0, pos[1]);
        drive(0, 1'b0, 7, 2);
        $display("test single capture done");
        xfer(IDX_CONTROL, 1'b1, 32'h3300, 1'b0, 32'h0);
        xfer(IDX_STATUS, 1'b0, 32'h0, 1'b0, 32'h0100);
        for (int k = 0; k < 5; k++)
            drive(1, (k % 2) == 0, k + 2, 8);
        xfer(IDX_STATUS, 1'b0, 32'h0, 1'b0, 32'h4700);
        xfer(IDX_P2_RISE, 1'b0, 32'h0, 1'b0, pos[6]);
        xfer(IDX_P2_FALL, 1'b0, 32'h0, 1'b0, pos[5]);
        $display("test continuous count done");
        xfer(IDX_CONTROL, 1'b1, 32'h0015, 1'b0, 32'h0);
        drive(0, 1'b1, 2, 8);
        drive(0, 1'b0, 2, 8);
        xfer(IDX_STATUS, 1'b0, 32'h0, 1'b0, 32'h0001);
        drive(3, 1'b1, 0, 3);
        drive(3, 1'b0, 1, 8);
        xfer(IDX_STATUS, 1'b0, 32'h0, 1'b0, 32'h0003);
        xfer(IDX_P1_RISE, 1'b0, 32'h0, 1'b0, pos[0]);
        $display("test zero pulse source done");
        xfer(IDX_CONTROL, 1'b1, 32'h0000, 1'b0, 32'h0);
        xfer(IDX_CONTROL, 1'b1, 32'h0011, 1'b0, 32'h0);
        probe_filter_time_i <= 10'h064;
        drive(0, 1'b1, 3, 10);
        drive(0, 1'b0, 3, 40);
        xfer(IDX_STATUS, 1'b0, 32'h0, 1'b0, 32'h0001);
        drive(0, 1'b1, 4, 40);
        xfer(IDX_STATUS, 1'b0, 32'h0, 1'b0, 32'h0003);
        xfer(IDX_P1_RISE, 1'b0, 32'h0, 1'b0, pos[4]);
        drive(0, 1'b0, 4, 40);
        $display("test input filter done");
        rst_b_i <= 1'b0;
        probe1_pin_select_i <= 2'h2;
        probe1_polarity_i <= 1'b1;
        pin_high <= 3'h4;
        probe_filter_time_i <= 10'h000;
        repeat (6) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        xfer(IDX_CONTROL, 1'b1, 32'h0011, 1'b0, 32'h0);
        drive(2, 1'b1, 5, 8);
        xfer(IDX_STATUS, 1'b0, 32'h0, 1'b0, 32'h0003);
        xfer(IDX_P1_RISE, 1'b0, 32'h0, 1'b0, pos[5]);
        $display("test restart settings done");
        repeat (4) @(posedge clk_sys_i);
        chk("pending answers", exp_q.size(), 32'h0);
        report_and_stop();
    end
endmodule // touch_probe_position_latch_tb

bind touch_probe_position_latch touch_probe_position_latch_checker
    i_touch_probe_position_latch_checker (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .obj_index_i(obj_index_i),
    .obj_rd_i(obj_rd_i), .obj_wr_i(obj_wr_i), .obj_wdata_i(obj_wdata_i),
    .obj_rdata_o(obj_rdata_o), .obj_ack_o(obj_ack_o), .obj_err_o(obj_err_o));
